// ---- rtl/pwmlc_apb_slave.sv ----
/*
 * APB slave of the PWM channel: decodes addresses, holds the control and
 * buffered compare registers, and returns read data from a register.
 * Assumes the counter state is supplied by the channel core on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pwmlc_apb_slave (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output var  logic [31:0]          prdata,
	output var  logic                 pslverr,
	// Core side
	output var  pwmlc_pkg::pwmlc_ctrl_t ctrl,
	output var  logic [7:0]           period_buf,
	output var  logic [7:0]           duty_buf,
	output var  logic                 count_wr,
	input  wire logic [7:0]           count_val,
	input  wire logic [7:0]           period_act,
	input  wire logic [7:0]           duty_act,
	input  wire logic                 out_level
);
	import pwmlc_pkg::*;

	pwmlc_ctrl_t ctrl_ff, nxt_ctrl;
	logic [7:0]  per_ff, nxt_per;
	logic [7:0]  duty_ff, nxt_duty;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        err_ff, nxt_err;
	logic        cwr_ff, nxt_cwr;
	logic        access;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == PWMLC_OFF_CTRL) || (a == PWMLC_OFF_PERIOD) ||
		         (a == PWMLC_OFF_DUTY) || (a == PWMLC_OFF_COUNT) ||
		         (a == PWMLC_OFF_STATUS);
	endfunction

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	// Every access completes in its first access cycle; pready is driven high outside from the first clock after reset.
	always_comb begin
		access    = psel & penable;
		nxt_ctrl  = ctrl_ff;
		nxt_per   = per_ff;
		nxt_duty  = duty_ff;
		nxt_cwr   = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_err   = 1'b0;
		if (psel & ~penable) begin
			nxt_err   = ~mapped(paddr);
			nxt_rdata = 32'h0000_0000;
			if (~pwrite) begin
				unique case (paddr)
					PWMLC_OFF_CTRL:   nxt_rdata = {29'h0, ctrl_ff};
					PWMLC_OFF_PERIOD: nxt_rdata = {24'h0, per_ff};
					PWMLC_OFF_DUTY:   nxt_rdata = {24'h0, duty_ff};
					PWMLC_OFF_COUNT:  nxt_rdata = {24'h0, count_val};
					PWMLC_OFF_STATUS: nxt_rdata = {15'h0, out_level, period_act, duty_act};
					default:          nxt_rdata = 32'h0000_0000;
				endcase
			end
		end
		if (access & pwrite) begin
			unique case (paddr)
				PWMLC_OFF_CTRL: begin
					nxt_ctrl.run    = pwdata[PWMLC_BIT_RUN];
					nxt_ctrl.pol    = pwdata[PWMLC_BIT_POL];
					nxt_ctrl.center = pwdata[PWMLC_BIT_CENTER];
				end
				PWMLC_OFF_PERIOD: nxt_per  = pwdata[7:0];
				PWMLC_OFF_DUTY:   nxt_duty = pwdata[7:0];
				PWMLC_OFF_COUNT:  nxt_cwr  = 1'b1;
				default:          nxt_cwr  = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff  <= '0;
			per_ff   <= PWMLC_RST_PERIOD;
			duty_ff  <= PWMLC_RST_DUTY;
			cwr_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			err_ff   <= 1'b0;
		end else begin
			ctrl_ff  <= nxt_ctrl;
			per_ff   <= nxt_per;
			duty_ff  <= nxt_duty;
			cwr_ff   <= nxt_cwr;
			rdata_ff <= nxt_rdata;
			err_ff   <= nxt_err;
		end
	end

	assign ctrl       = ctrl_ff;
	assign period_buf = per_ff;
	assign duty_buf   = duty_ff;
	assign count_wr   = cwr_ff;
	assign prdata     = rdata_ff;
	assign pslverr    = err_ff;

endmodule
`default_nettype wire

// ---- rtl/pwmlc_pkg.sv ----
/*
 * Shared constants and carrier types for the left-aligned PWM channel.
 * Assumes a 32-bit APB register bus and a single pclk domain.
 */
package pwmlc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] PWMLC_OFF_CTRL   = 12'h000;
	localparam logic [11:0] PWMLC_OFF_PERIOD = 12'h004;
	localparam logic [11:0] PWMLC_OFF_DUTY   = 12'h008;
	localparam logic [11:0] PWMLC_OFF_COUNT  = 12'h00c;
	localparam logic [11:0] PWMLC_OFF_STATUS = 12'h010;

	// ----------------------------------------------------------------
	// Field positions in the control register
	// ----------------------------------------------------------------
	localparam int PWMLC_BIT_RUN    = 0;
	localparam int PWMLC_BIT_POL    = 1;
	localparam int PWMLC_BIT_CENTER = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PWMLC_RST_PERIOD = 8'hff;
	localparam logic [7:0] PWMLC_RST_DUTY   = 8'hff;
	localparam logic [7:0] PWMLC_RST_COUNT  = 8'h00;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       run;
		logic       pol;
		logic       center;
	} pwmlc_ctrl_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] data;
	} pwmlc_wr_t;

endpackage

// ---- rtl/pwmlc_counter.sv ----
/*
 * Eight-bit up counter with period match, enable hold and clear.
 * Assumes all controls arrive synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pwmlc_counter #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Control
	input  wire logic             run,
	input  wire logic             clear,
	input  wire logic [WIDTH-1:0] period,
	// State
	output var  logic [WIDTH-1:0] count,
	output var  logic             period_hit
);
	import pwmlc_pkg::*;

	logic [WIDTH-1:0] cnt_ff, nxt_cnt;
	logic             hit;

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	// Matching count+1 to period ends the cycle at period-1, so period 0 or 1 both hold at zero.
	always_comb begin
		hit     = run & ((cnt_ff + WIDTH'(1)) >= period);
		nxt_cnt = cnt_ff;
		if (clear) begin
			nxt_cnt = '0;
		end else if (run) begin
			if (hit) begin
				nxt_cnt = '0;
			end else begin
				nxt_cnt = cnt_ff + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign count      = cnt_ff;
	assign period_hit = hit & ~clear;

endmodule
`default_nettype wire

// ---- rtl/pwmlc_top.sv ----
/*
 * Left-aligned PWM channel: APB register set, up counter, duty and period
 * compare with double buffering, and the output flip-flop driving the pin.
 * Assumes a single pclk domain; the output pin drives an external load.
 */
//
// Behaviour
// - With the centre-align bit clear the channel produces a left-aligned waveform.
// - The left-aligned counter is eight bits wide and counts only upward.
// - When running left-aligned, a match of count and active duty toggles the output flip-flop unless a period match or counter write falls in the same cycle.
// - A period match clears the counter, sets the output by polarity and loads the buffered duty and period.
// - The counter runs from zero to one below the active period and then wraps.
// - Any write to the counter clears it, reloads duty and period, and sets output by polarity.
// - Clearing the run bit halts the counter, which resumes from its held value when set.
// - Reading the counter never disturbs the count or the channel.
`timescale 1ns/1ps
`default_nettype none
module pwmlc_top #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// PWM pin
	output var  logic        pwm_out
);
	import pwmlc_pkg::*;

	pwmlc_ctrl_t ctrl;
	logic [7:0]  period_buf, duty_buf, count;
	logic        count_wr, period_hit;
	logic [7:0]  per_act_ff, nxt_per_act;
	logic [7:0]  duty_act_ff, nxt_duty_act;
	logic        out_ff, nxt_out;
	logic        left_mode;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	pwmlc_apb_slave u_apb (
		.pclk       (pclk),
		.presetn    (presetn),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pslverr    (pslverr),
		.ctrl       (ctrl),
		.period_buf (period_buf),
		.duty_buf   (duty_buf),
		.count_wr   (count_wr),
		.count_val  (count),
		.period_act (per_act_ff),
		.duty_act   (duty_act_ff),
		.out_level  (out_ff)
	);

	// Zero wait states keep the bus simple; every access is answered at once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	pwmlc_counter #(.WIDTH(WIDTH)) u_cnt (
		.pclk       (pclk),
		.presetn    (presetn),
		.run        (ctrl.run & left_mode),
		.clear      (count_wr),
		.period     (per_act_ff),
		.count      (count),
		.period_hit (period_hit)
	);

	// ----------------------------------------------------------------
	// Compare and output
	// ----------------------------------------------------------------
	// Centre mode is not built here; with the select set the channel holds still.
	always_comb begin
		left_mode    = ~ctrl.center;
		nxt_per_act  = per_act_ff;
		nxt_duty_act = duty_act_ff;
		nxt_out      = out_ff;
		if (count_wr || period_hit) begin
			nxt_per_act  = period_buf;
			nxt_duty_act = duty_buf;
			nxt_out      = ctrl.pol;
		end else if (ctrl.run && left_mode && (count == duty_act_ff)) begin
			nxt_out = ~out_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_act_ff  <= PWMLC_RST_PERIOD;
			duty_act_ff <= PWMLC_RST_DUTY;
			out_ff      <= 1'b0;
			pwm_out     <= 1'b0;
		end else begin
			per_act_ff  <= nxt_per_act;
			duty_act_ff <= nxt_duty_act;
			out_ff      <= nxt_out;
			pwm_out     <= nxt_out;
		end
	end

endmodule
`default_nettype wire

// ---- verification/pwmlc_load.sv ----
/* Load on the PWM pin: counts the clock edges seen with the pin high.
   Assumes the pin is sampled on pclk. */
`timescale 1ns/1ps
`default_nettype none
module pwmlc_load (
	// Pin side
	input  wire logic pclk,
	input  wire logic pwm_out,
	output var  int   hi_cnt
);
	int hi_ff = 0;
	// A counter, not a filter: the bench judges duty over whole periods.
	always @(posedge pclk) if (pwm_out === 1'b1) hi_ff <= hi_ff + 1;
	assign hi_cnt = hi_ff;
endmodule
`default_nettype wire

// ---- verification/pwmlc_top_sva.sv ----
/* Port checker of the PWM channel.
   Assumes it is bound onto pwmlc_top. */
`timescale 1ns/1ps
`default_nettype none
module pwmlc_top_sva #(
	parameter int WIDTH = 8
) (
	// Watched ports
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pwm_out
);
	logic pol_ff;
	logic acc;
	logic rd;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pol_ff <= 1'b0;
		else if (acc && pwrite && paddr == 12'h000) pol_ff <= pwdata[1];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_high: assert property ($past(presetn) |-> pready) else $error("pready low");
	a_err_unmapped: assert property (acc && paddr > 12'h010 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_err_mapped: assert property (acc && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("bad pslverr");
	a_narrow_read: assert property (rd && paddr < 12'h010 |-> prdata[31:8] == 24'h0)
		else $error("wide read");
	a_ctrl_read: assert property (rd && paddr == 12'h000 |-> prdata[31:3] == 29'h0)
		else $error("ctrl read");
	a_status_read: assert property (rd && paddr == 12'h010 |-> prdata[31:17] == 15'h0)
		else $error("status read");
	a_clear_pol: assert property (acc && pwrite && paddr == 12'h00c |-> ##2 pwm_out == pol_ff)
		else $error("clear level");
	a_rst_quiet: assert property (disable iff (1'b0) !presetn |-> !pwm_out && !pready && !pslverr)
		else $error("reset outputs");
endmodule
bind pwmlc_top pwmlc_top_sva #(.WIDTH(WIDTH)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
`default_nettype wire

// ---- verification/tb.sv ----
/* Self-checking bench of the PWM channel.
   Assumes pwmlc_top, the load model and the checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, v) begin check_count++; if ((e) !== (v)) begin failures++; \
	$display("wrong value %s exp %0h got %0h", nm, e, v); end end
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_out, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, c1;
	int failures, check_count, hi_cnt, k;
	int cyc = 0;
	pwmlc_top #(.WIDTH(8)) pwmlc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
	pwmlc_load pwmlc_load_inst (.pclk(pclk), .pwm_out(pwm_out), .hi_cnt(hi_cnt));
	initial begin pclk = 0; forever #20 pclk = ~pclk; end
	// ----------------------------------------------------------------
	// Bus and measuring tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
		@(posedge pclk) penable <= 1;
		do begin @(posedge pclk); end while (pready !== 1'b1);
		r = prdata; er = pslverr; psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask
	task automatic hi(input int n);
		int h0;
		h0 = hi_cnt; repeat (n) @(posedge pclk); k = hi_cnt - h0;
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		apb(0, 12'h000, 0); `CHK("ctrl", 32'h0, r)
		apb(0, 12'h004, 0); `CHK("period", 32'hff, r)
		apb(0, 12'h008, 0); `CHK("duty", 32'hff, r)
		apb(0, 12'h00c, 0); `CHK("count", 32'h0, r)
		apb(0, 12'h010, 0); `CHK("status", 32'hffff, r)
		apb(0, 12'h020, 0); `CHK("unmapped", 33'h100000000, {er, r})
		apb(1, 12'h010, 32'h0); apb(0, 12'h010, 0); `CHK("status ro", 32'hffff, r)
	endtask
	task automatic t_wave;
		apb(1, 12'h004, 10); apb(1, 12'h008, 2); apb(1, 12'h00c, 0); apb(1, 12'h000, 1);
		apb(0, 12'h00c, 0); c1 = r; apb(0, 12'h00c, 0);
		`CHK("step", (c1 + 3) % 10, r)
		for (int i = 0; i < 12; i++) begin apb(0, 12'h00c, 0); `CHK("range", 1'b1, r < 10) end
		hi(20); `CHK("high pol0", 14, k)
		apb(1, 12'h000, 3); apb(1, 12'h00c, 0); apb(0, 12'h00c, 0);
		hi(20); `CHK("high pol1", 6, k)
	endtask
	task automatic t_halt;
		apb(1, 12'h000, 2); apb(0, 12'h00c, 0); c1 = r; hi(10);
		apb(0, 12'h00c, 0); `CHK("held", c1, r)
		`CHK("pin still", 1'b1, k == 0 || k == 10)
		apb(1, 12'h000, 3); apb(0, 12'h00c, 0);
		`CHK("resume", 1'b1, r != c1 && (r + 10 - c1) % 10 < 4)
		apb(1, 12'h000, 7); apb(0, 12'h00c, 0); c1 = r; apb(0, 12'h00c, 0);
		`CHK("center stop", c1, r)
		apb(1, 12'h00c, 5); apb(0, 12'h00c, 0); `CHK("cleared", 32'h0, r)
	endtask
	task automatic t_reload;
		apb(1, 12'h000, 1); apb(1, 12'h00c, 0); apb(1, 12'h004, 20); apb(1, 12'h008, 7);
		apb(0, 12'h010, 0); `CHK("old act", 16'h0a02, r[15:0])
		repeat (12) @(posedge pclk);
		apb(0, 12'h010, 0); `CHK("new act", 16'h1407, r[15:0])
		apb(1, 12'h008, 3); apb(1, 12'h00c, 0);
		apb(0, 12'h010, 0); `CHK("count load", 8'h03, r[7:0])
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin failures++; finish_test; end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} <= '0;
		failures = 0; check_count = 0; presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset; t_wave; t_halt; t_reload;
		finish_test;
	end
endmodule
`default_nettype wire
